//--- common/psc_pkg.sv
package psc_pkg;
   // ----------------------------------------
   // Register map (word index = byte addr / 4)
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL     = 8'h00; // Commands and full-scale select
   localparam logic [7:0] ADDR_STATUS   = 8'h04; // Flags and power state
   localparam logic [7:0] ADDR_CH_ON    = 8'h08; // Per-channel on bits
   localparam logic [7:0] ADDR_WARN_TH  = 8'h0C; // Supply warning threshold
   localparam logic [7:0] ADDR_HOLD     = 8'h10; // Startup hold time
   localparam logic [7:0] ADDR_CODE0    = 8'h40; // First current code word

   // ----------------------------------------
   // Control bit positions
   // ----------------------------------------
   localparam int CTRL_RELOAD   = 0;
   localparam int CTRL_CLR_POR  = 1;
   localparam int CTRL_CLR_FLT  = 2;
   localparam int CTRL_FS_LO    = 4;

   // ----------------------------------------
   // Status bit positions
   // ----------------------------------------
   localparam int ST_POR   = 0;
   localparam int ST_FAULT = 1;
   localparam int ST_UV    = 2;
   localparam int ST_WARN  = 3;
   localparam int ST_OPEN  = 4;
   localparam int ST_SLS   = 5;
   localparam int ST_STATE = 8;

   // ----------------------------------------
   // Widths and reset values
   // ----------------------------------------
   localparam int CODE_W   = 6;
   localparam int TH_W     = 5;
   localparam int FS_W     = 2;
   localparam logic [1:0]  FS_DEFAULT = 2'h3;   // x512
   localparam logic [5:0]  CODE_DEFAULT = 6'h00;
   localparam logic [4:0]  TH_DEFAULT = 5'h00;  // 4 V
   localparam logic [31:0] ZERO32 = 32'h0000_0000;

   // Power states
   typedef enum logic [1:0] {
      PSC_SLEEP,
      PSC_POR,
      PSC_START,
      PSC_NORMAL
   } psc_state_e;
endpackage

//--- rtl/psc_power_seq.sv
`timescale 1ns/1ns
module psc_power_seq
   import psc_pkg::*;
#(
   parameter int NCH = 16,
   parameter int HOLD_W = 16
) (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    clk_en,
   // Supplies and enable, as digital levels
   input  wire logic                    enable_in,
   input  wire logic                    bias_ok,
   input  wire logic                    internal_regulator_output_ok,
   input  wire logic                    output_supply_under,
   input  wire logic [TH_W-1:0]         supply_level,      // Supply in volts minus 4
   // Nonvolatile settings
   input  wire logic [HOLD_W-1:0]       nv_startup_hold_time,
   input  wire logic [TH_W-1:0]         nv_supply_warn_threshold,
   input  wire logic [FS_W-1:0]         nv_full_scale_select,
   // Raw detector events from the channel diagnostics
   input  wire logic                    open_detect,
   input  wire logic                    short_detect,
   // Register port
   input  wire logic [7:0]              addr,
   input  wire logic [31:0]             wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic      [31:0]             rdata,
   // Analog side controls
   output logic      [NCH-1:0]          current_output_channel_on,
   output logic      [NCH*CODE_W-1:0]   channel_current_code,
   output logic      [FS_W-1:0]         full_scale_select,
   output logic      [9:0]              full_scale_mult,
   output logic                         detect_enable,
   output logic                         fault_pin_o,
   output logic                         fault_pin_oe_n,
   output logic                         core_active
);
   import psc_pkg::*;

   // ----------------------------------------
   // State and registers
   // ----------------------------------------
   psc_state_e              state;
   psc_state_e              next_state;
   logic [HOLD_W-1:0]       hold_cnt;
   logic [NCH-1:0]          channel_on_bit;
   logic [CODE_W-1:0]       code_mem [NCH];
   logic [FS_W-1:0]         fs_reg;
   logic [TH_W-1:0]         supply_warn_threshold;
   logic [HOLD_W-1:0]       startup_hold_time;
   logic                    por_flag;
   logic                    fault_flag;
   logic                    output_supply_under_flag;
   logic                    supply_warn_flag;
   logic                    open_flag;
   logic                    sls_flag;
   logic                    nv_load_pending;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire supplies_ok   = bias_ok && internal_regulator_output_ok;
   wire in_lockout    = !supplies_ok;
   wire sleeping      = bias_ok && !enable_in;
   wire wr_ctrl       = wr && addr == ADDR_CTRL;
   wire reload_defaults_cmd = wr_ctrl && wdata[CTRL_RELOAD];
   wire clear_power_on_cmd  = wr_ctrl && wdata[CTRL_CLR_POR];
   wire clear_fault_cmd     = wr_ctrl && wdata[CTRL_CLR_FLT];
   wire warn_now      = supply_level < supply_warn_threshold;
   wire detect_ok     = !warn_now && !output_supply_under;
   wire open_ev       = open_detect && detect_ok;
   wire sls_ev        = short_detect && detect_ok;
   wire drive_ok      = state == PSC_NORMAL && !output_supply_under;
   wire code_hit      = addr >= ADDR_CODE0 && addr < ADDR_CODE0 + 8'(NCH*4);
   wire [7:0] code_off = addr - ADDR_CODE0;
   wire [3:0] code_idx = code_off[5:2];
   // Compare with >= so a hold time rewritten below the count still ends startup
   wire hold_done     = hold_cnt >= startup_hold_time;

   // Multiplier table for the full-scale select
   wire [9:0] mult_sel = (fs_reg == 2'h3) ? 10'h200 :
                         (fs_reg == 2'h2) ? 10'h100 :
                         (fs_reg == 2'h1) ? 10'h080 : 10'h040;

   // Read mux; reading is side-effect free
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = ZERO32;
      if (addr == ADDR_CTRL) begin
         next_rdata[CTRL_FS_LO +: FS_W] = fs_reg; // Commands read back as 0
      end else if (addr == ADDR_STATUS) begin
         next_rdata[ST_POR]   = por_flag;
         next_rdata[ST_FAULT] = fault_flag;
         next_rdata[ST_UV]    = output_supply_under_flag;
         next_rdata[ST_WARN]  = supply_warn_flag;
         next_rdata[ST_OPEN]  = open_flag;
         next_rdata[ST_SLS]   = sls_flag;
         next_rdata[ST_STATE +: 2] = state;
      end else if (addr == ADDR_CH_ON) begin
         next_rdata[NCH-1:0] = channel_on_bit;
      end else if (addr == ADDR_WARN_TH) begin
         next_rdata[TH_W-1:0] = supply_warn_threshold;
      end else if (addr == ADDR_HOLD) begin
         next_rdata[HOLD_W-1:0] = startup_hold_time;
      end else if (code_hit) begin
         next_rdata[CODE_W-1:0] = code_mem[code_idx];
      end
   end

   // ----------------------------------------
   // Power state machine
   // ----------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         PSC_SLEEP: begin
            if (enable_in) next_state = PSC_POR;
         end
         PSC_POR: begin
            if (supplies_ok) next_state = PSC_START;
         end
         PSC_START: begin
            if (clear_power_on_cmd || hold_done) next_state = PSC_NORMAL;
         end
         PSC_NORMAL: ;
         default: next_state = PSC_POR;
      endcase
      if (in_lockout) next_state = PSC_POR;
      if (sleeping) next_state = PSC_SLEEP;
   end

   // Lockout or sleep acts as a register reset: the core is unpowered there.
   // It waits for the clock enable, so a frozen core keeps every bit it holds except hold_cnt, which still clears outside startup.
   wire core_reset = !rst_n || (clk_en && (in_lockout || sleeping));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= PSC_POR;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // Startup hold counter runs only in the startup state
   always_ff @(posedge clk) begin
      if (core_reset || state != PSC_START) begin
         hold_cnt <= '0;
      end else if (clk_en && !hold_done) begin
         hold_cnt <= hold_cnt + 1'b1;
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   // Nonvolatile-backed fields reload on power-up and on the reload command
   always_ff @(posedge clk) begin
      if (core_reset) begin
         nv_load_pending <= 1'b1;
         channel_on_bit  <= '0;
      end else if (clk_en) begin
         nv_load_pending <= 1'b0;
         if (reload_defaults_cmd) begin
            channel_on_bit <= '0;
         end else if (wr && addr == ADDR_CH_ON) begin
            channel_on_bit <= wdata[NCH-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en && (nv_load_pending || reload_defaults_cmd)) begin
         supply_warn_threshold <= nv_supply_warn_threshold;
         fs_reg                <= nv_full_scale_select;
         startup_hold_time     <= nv_startup_hold_time;
      end else if (clk_en) begin
         if (wr_ctrl) fs_reg <= wdata[CTRL_FS_LO +: FS_W];
         if (wr && addr == ADDR_WARN_TH) supply_warn_threshold <= wdata[TH_W-1:0];
         if (wr && addr == ADDR_HOLD) startup_hold_time <= wdata[HOLD_W-1:0];
      end
   end

   // Current codes, one word per channel; code_out is their registered copy
   logic [CODE_W-1:0] code_out [NCH];
   generate
      for (genvar i = 0; i < NCH; i++) begin : g_code
         always_ff @(posedge clk) begin
            if (core_reset) begin
               code_mem[i] <= CODE_DEFAULT;
            end else if (clk_en) begin
               if (reload_defaults_cmd) begin
                  code_mem[i] <= CODE_DEFAULT;
               end else if (wr && code_hit && code_idx == 4'(i)) begin
                  code_mem[i] <= wdata[CODE_W-1:0];
               end
            end
         end
         assign channel_current_code[i*CODE_W +: CODE_W] = code_out[i];
      end
   endgenerate

   // ----------------------------------------
   // Flags: set wins over clear
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (core_reset) begin
         por_flag   <= 1'b1;
         fault_flag <= 1'b1;
         output_supply_under_flag <= 1'b0;
         supply_warn_flag <= 1'b0;
         open_flag  <= 1'b0;
         sls_flag   <= 1'b0;
      end else if (clk_en) begin
         // Power-on flag: cleared by either command
         if (clear_power_on_cmd || reload_defaults_cmd) por_flag <= 1'b0;
         output_supply_under_flag <= output_supply_under ||
            (output_supply_under_flag && !clear_fault_cmd && !reload_defaults_cmd);
         supply_warn_flag <= warn_now ||
            (supply_warn_flag && !clear_fault_cmd && !reload_defaults_cmd);
         // Warning wipes pending open and short faults
         open_flag <= open_ev ||
            (open_flag && !warn_now && !clear_fault_cmd && !reload_defaults_cmd);
         sls_flag  <= sls_ev ||
            (sls_flag && !warn_now && !clear_fault_cmd && !reload_defaults_cmd);
         // Summary flag; power-on alone keeps it up until a fault clear or reload command
         fault_flag <= output_supply_under || warn_now || open_ev || sls_ev ||
            (fault_flag && !clear_fault_cmd && !reload_defaults_cmd);
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata                     <= ZERO32;
         current_output_channel_on <= '0;
         full_scale_select         <= FS_DEFAULT;
         full_scale_mult           <= 10'h200;
         detect_enable             <= 1'b0;
         fault_pin_o               <= 1'b0;
         fault_pin_oe_n            <= 1'b0;                        // Pulled low in reset
         core_active               <= 1'b0;
         for (int k = 0; k < NCH; k++) code_out[k] <= CODE_DEFAULT;
      end else if (clk_en) begin
         rdata <= rd ? next_rdata : ZERO32;
         // Drop all channels at once when enable falls or supply fails
         current_output_channel_on <= (drive_ok && !sleeping && !in_lockout &&
                                       next_state == PSC_NORMAL) ? channel_on_bit : '0;
         full_scale_select <= fs_reg;
         full_scale_mult   <= mult_sel;
         detect_enable     <= detect_ok && state == PSC_NORMAL;
         fault_pin_o       <= 1'b0;
         // Pin held low in lockout except while sleeping, and during output supply under
         fault_pin_oe_n    <= !(next_state == PSC_POR || output_supply_under);
         core_active       <= !sleeping;
         for (int k = 0; k < NCH; k++) code_out[k] <= code_mem[k];
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_sleep_outputs_off: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && sleeping |=> current_output_channel_on == '0 && !core_active)
      else $error("outputs active while sleeping");
   a_enable_drop: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && bias_ok && $fell(enable_in) |=> current_output_channel_on == '0)
      else $error("outputs not off after enable drop");
   a_lockout_state: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && in_lockout && enable_in |=> state == PSC_POR && por_flag && fault_flag)
      else $error("lockout did not reset");
   a_lockout_pin: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && in_lockout && enable_in |=> !fault_pin_oe_n && current_output_channel_on == '0)
      else $error("fault pin not pulled in lockout");
   a_start_release: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && state == PSC_POR && supplies_ok && enable_in && !output_supply_under
      |=> state == PSC_START && fault_pin_oe_n)
      else $error("startup entry wrong");
   a_clear_power_on_cmd_jump: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && state == PSC_START && clear_power_on_cmd && supplies_ok && enable_in
      |=> state == PSC_NORMAL && !por_flag)
      else $error("clear power-on did not jump");
   a_uv_flags: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && output_supply_under && supplies_ok && enable_in
      |=> output_supply_under_flag && fault_flag && current_output_channel_on == '0)
      else $error("undervoltage response wrong");
   a_warn_clears: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && warn_now && supplies_ok && enable_in |=> supply_warn_flag && !open_flag && !sls_flag)
      else $error("warning handling wrong");
   a_fs_mult: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && fs_reg == 2'h0 |=> full_scale_mult == 10'h040)
      else $error("scale multiplier wrong");

   // ----------------------------------------
   // Checks on timing, commands and write paths
   // ----------------------------------------
   // Startup timer and nonvolatile load
   a_hold_counts: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && state == PSC_START && !hold_done && !core_reset && !clear_power_on_cmd
      |=> state == PSC_START && hold_cnt == $past(hold_cnt) + 1'b1)
      else $error("startup timer did not count");
   a_hold_expiry: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && state == PSC_START && hold_done && !core_reset |=> state == PSC_NORMAL)
      else $error("startup timer did not end");
   a_nv_load: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && nv_load_pending |=> supply_warn_threshold == $past(nv_supply_warn_threshold) &&
      fs_reg == $past(nv_full_scale_select) && startup_hold_time == $past(nv_startup_hold_time))
      else $error("nonvolatile settings not loaded");
   // Commands, sticky holds and the lockout or sleep reset; each command must win over the sticky hold of its flag
   a_reload_regs: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && reload_defaults_cmd && !core_reset
      |=> !por_flag && channel_on_bit == '0 && code_mem[0] == CODE_DEFAULT)
      else $error("reload did not restore defaults");
   a_clear_por: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && clear_power_on_cmd && !core_reset |=> !por_flag)
      else $error("power-on flag not cleared");
   a_clear_fault: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && clear_fault_cmd && !core_reset && detect_ok && !open_detect && !short_detect
      |=> !fault_flag && !supply_warn_flag && !output_supply_under_flag && !open_flag && !sls_flag)
      else $error("fault flags not cleared");
   a_warn_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !core_reset && supply_warn_flag && !clear_fault_cmd && !reload_defaults_cmd
      |=> supply_warn_flag)
      else $error("warning flag lost");
   a_por_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !core_reset && por_flag && !clear_power_on_cmd && !reload_defaults_cmd |=> por_flag)
      else $error("power-on flag lost");
   a_reset_defaults: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && (in_lockout || sleeping) |=> channel_on_bit == '0 && por_flag && fault_flag)
      else $error("registers not reset");
   // Outputs and write paths
   a_off_unless_normal: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && next_state != PSC_NORMAL |=> current_output_channel_on == '0)
      else $error("channel driven outside normal state");
   a_uv_pin: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && output_supply_under |=> !fault_pin_oe_n && !fault_pin_o)
      else $error("fault pin released in undervoltage");
   a_detect_mask: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !detect_ok |=> !detect_enable)
      else $error("detection enabled below threshold");
   a_mult_table: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en |=> full_scale_mult == (10'h040 << $past(fs_reg)))
      else $error("scale table wrong");
   a_code_write: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !core_reset && wr && code_hit |=> code_mem[$past(code_idx)] == $past(wdata[CODE_W-1:0]))
      else $error("current code write lost");
   a_channel_write: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en && !core_reset && wr && addr == ADDR_CH_ON |=> channel_on_bit == $past(wdata[NCH-1:0]))
      else $error("channel on bits write lost");
endmodule // psc_power_seq

//--- test/psc_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module psc_host_model (
   // Clock
   input  wire logic        clk,
   // Register port toward the device
   output logic      [7:0]  addr,
   output logic      [31:0] wdata,
   output logic             wr,
   output logic             rd,
   input  wire logic [31:0] rdata
);
   // Idle lines at time zero
   initial begin
      addr = 8'h00;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
   end

   // A released bus flips its lines so stale values never look valid
   task automatic release_bus();
      wr <= 1'b0;
      rd <= 1'b0;
      addr <= ~addr;
      wdata <= ~wdata;
   endtask

   // One-cycle write strobe
   task automatic write_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      release_bus();
   endtask

   // One-cycle read strobe, data taken in the following cycle only
   task automatic read_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      release_bus();
      @(posedge clk);
      v = rdata;
   endtask
endmodule // psc_host_model

//--- test/tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end
module tb;
   import psc_pkg::*;
   // Short hold keeps the run brief
   localparam int HOLD = 60;
   logic              clk, rst_n, enable_in, bias_ok, reg_ok, out_under, open_det, short_det;
   logic [4:0]        supply_level, nv_th, th;
   logic [1:0]        nv_fs, fs;
   logic [7:0]        addr;
   logic [31:0]       wdata, rdata, d;
   logic              wr, rd, det_en, pin_o, pin_oe_n, active, clk_en;
   logic [15:0]       ch_on, on_v;
   logic [95:0]       codes;
   logic [9:0]        mult;
   logic [5:0]        code_q [16];
   int                err_count, n_tests;
   integer            seed;

   // ----------------------------------------
   // Device and host
   // ----------------------------------------
   psc_power_seq #(.NCH(16), .HOLD_W(16)) u_psc_power_seq (
      .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .enable_in(enable_in), .bias_ok(bias_ok),
      .internal_regulator_output_ok(reg_ok), .output_supply_under(out_under), .supply_level(supply_level),
      .nv_startup_hold_time(16'(HOLD)), .nv_supply_warn_threshold(nv_th), .nv_full_scale_select(nv_fs),
      .open_detect(open_det), .short_detect(short_det), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .current_output_channel_on(ch_on), .channel_current_code(codes),
      .full_scale_select(fs), .full_scale_mult(mult), .detect_enable(det_en), .fault_pin_o(pin_o),
      .fault_pin_oe_n(pin_oe_n), .core_active(active));
   psc_host_model u_psc_host_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [9:0] mult_of(input logic [1:0] f);
      return 10'h040 << f;
   endfunction
   // Control word keeps the full-scale field so commands do not disturb it
   function automatic logic [31:0] ctrl(input int b, input logic [1:0] f);
      return (32'h0000_0001 << b) | (32'(f) << CTRL_FS_LO);
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      u_psc_host_model.write_reg(a, v);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      u_psc_host_model.read_reg(a, v);
   endtask
   task automatic power(input logic b, input logic r, input logic e);
      @(posedge clk);
      bias_ok <= b;
      reg_ok <= r;
      enable_in <= e;
   endtask
   task automatic complete_run();
      $display("errors %0d of %0d checks", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Watchdog well beyond the expected run length
   initial begin
      #(40 * (6 * HOLD + 3000));
      err_count++;
      complete_run();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h5995;
      err_count = 0;
      n_tests = 0;
      rst_n = 1'b0;
      clk_en = 1'b1;
      {enable_in, bias_ok, reg_ok} = 3'h7;
      {out_under, open_det, short_det} = 3'h0;
      supply_level = 5'h1F;
      nv_th = 5'($random(seed)) | 5'h01;
      nv_fs = 2'($random(seed));
      tick(4);
      `CHK(pin_oe_n, 1'b0)
      `CHK(pin_o, 1'b0)
      `CHK(ch_on, 16'h0000)
      @(posedge clk);
      rst_n <= 1'b1;
      tick(3);
      `CHK(pin_oe_n, 1'b1)
      rd_reg(ADDR_STATUS, d);
      `CHK(d[ST_POR], 1'b1)
      `CHK(d[ST_FAULT], 1'b1)
      `CHK(d[9:8], PSC_START)
      rd_reg(ADDR_WARN_TH, d);
      `CHK(d[4:0], nv_th)
      rd_reg(ADDR_HOLD, d);
      `CHK(d[15:0], 16'(HOLD))
      `CHK(mult, mult_of(nv_fs))
      tick(HOLD);
      rd_reg(ADDR_STATUS, d);
      `CHK(d[9:8], PSC_NORMAL)
      // Host reloads defaults after the first reset
      wr_reg(ADDR_CTRL, ctrl(CTRL_RELOAD, nv_fs));
      rd_reg(ADDR_STATUS, d);
      `CHK(d[ST_POR], 1'b0)
      rd_reg(ADDR_CTRL, d);
      `CHK(d[CTRL_RELOAD], 1'b0)
      // Random on bits and codes, with both code extremes
      on_v = 16'($random(seed));
      wr_reg(ADDR_CH_ON, 32'(on_v));
      for (int i = 0; i < 16; i++) begin
         code_q[i] = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : 6'($random(seed));
         wr_reg(ADDR_CODE0 + 8'(4 * i), 32'(code_q[i]));
      end
      tick(1);
      `CHK(ch_on, on_v)
      for (int i = 0; i < 16; i++) begin
         `CHK(codes[i*6 +: 6], code_q[i])
         rd_reg(ADDR_CODE0 + 8'(4 * i), d);
         `CHK(d[5:0], code_q[i])
      end
      for (int f = 0; f < 4; f++) begin
         wr_reg(ADDR_CTRL, 32'(f) << CTRL_FS_LO);
         tick(1);
         `CHK(fs, 2'(f))
         `CHK(mult, mult_of(2'(f)))
      end
      // Frozen clock enable holds the outputs; undervoltage acts once it runs again
      @(posedge clk);
      clk_en <= 1'b0;
      out_under <= 1'b1;
      tick(3);
      `CHK(ch_on, on_v)
      @(posedge clk);
      clk_en <= 1'b1;
      tick(2);
      `CHK(ch_on, 16'h0000)
      @(posedge clk);
      out_under <= 1'b0;
      // Unmapped place reads zero and a write there changes nothing
      wr_reg(8'h3C, 32'hFFFF_FFFF);
      rd_reg(8'h3C, d);
      `CHK(d, ZERO32)
      rd_reg(ADDR_CH_ON, d);
      `CHK(d[15:0], on_v)
      // Open fault at the threshold boundary, then a warning wipes it
      th = 5'($random(seed)) | 5'h01;
      wr_reg(ADDR_WARN_TH, 32'(th));
      @(posedge clk);
      supply_level <= th;
      open_det <= 1'b1;
      tick(3);
      `CHK(det_en, 1'b1)
      @(posedge clk);
      open_det <= 1'b0;
      rd_reg(ADDR_STATUS, d);
      `CHK(d[ST_OPEN], 1'b1)
      `CHK(d[ST_WARN], 1'b0)
      @(posedge clk);
      supply_level <= th - 5'h01;
      short_det <= 1'b1;
      tick(3);
      `CHK(det_en, 1'b0)
      rd_reg(ADDR_STATUS, d);
      `CHK(d[ST_WARN], 1'b1)
      `CHK(d[ST_FAULT], 1'b1)
      `CHK(d[ST_OPEN], 1'b0)
      `CHK(d[ST_SLS], 1'b0)
      @(posedge clk);
      supply_level <= 5'h1F;
      short_det <= 1'b0;
      tick(3);
      rd_reg(ADDR_STATUS, d);
      `CHK(d[ST_WARN], 1'b1)
      wr_reg(ADDR_CTRL, ctrl(CTRL_CLR_FLT, 2'h3));
      rd_reg(ADDR_STATUS, d);
      `CHK(d[ST_WARN], 1'b0)
      `CHK(d[ST_FAULT], 1'b0)
      // Output supply undervoltage
      @(posedge clk);
      out_under <= 1'b1;
      tick(3);
      `CHK(ch_on, 16'h0000)
      `CHK(pin_oe_n, 1'b0)
      rd_reg(ADDR_STATUS, d);
      `CHK(d[ST_UV], 1'b1)
      `CHK(d[ST_FAULT], 1'b1)
      @(posedge clk);
      out_under <= 1'b0;
      tick(3);
      rd_reg(ADDR_STATUS, d);
      `CHK(d[ST_UV], 1'b1)
      wr_reg(ADDR_CTRL, ctrl(CTRL_CLR_FLT, 2'h3));
      rd_reg(ADDR_STATUS, d);
      `CHK(d[ST_UV], 1'b0)
      // Sleep, then a full restart with clear-power-on in normal state
      power(1'b1, 1'b1, 1'b0);
      tick(3);
      `CHK(ch_on, 16'h0000)
      `CHK(active, 1'b0)
      power(1'b1, 1'b1, 1'b1);
      tick(HOLD + 10);
      `CHK(active, 1'b1)
      rd_reg(ADDR_STATUS, d);
      `CHK(d[ST_POR], 1'b1)
      `CHK(d[9:8], PSC_NORMAL)
      wr_reg(ADDR_CTRL, ctrl(CTRL_CLR_POR, ~nv_fs));
      rd_reg(ADDR_STATUS, d);
      `CHK(d[ST_POR], 1'b0)
      rd_reg(ADDR_CH_ON, d);
      `CHK(d[15:0], 16'h0000)
      // Move code and threshold off their loaded values so the lockout has work to undo
      wr_reg(ADDR_CODE0, 32'h0000_003F);
      wr_reg(ADDR_WARN_TH, 32'(~nv_th));
      // Regulator lockout, then clear-power-on cuts the startup short
      power(1'b1, 1'b0, 1'b1);
      tick(3);
      `CHK(pin_oe_n, 1'b0)
      `CHK(mult, mult_of(nv_fs))
      power(1'b1, 1'b1, 1'b1);
      tick(3);
      `CHK(pin_oe_n, 1'b1)
      wr_reg(ADDR_CTRL, ctrl(CTRL_CLR_POR, nv_fs));
      rd_reg(ADDR_STATUS, d);
      `CHK(d[9:8], PSC_NORMAL)
      `CHK(d[ST_POR], 1'b0)
      rd_reg(ADDR_CODE0, d);
      `CHK(d[5:0], CODE_DEFAULT)
      rd_reg(ADDR_WARN_TH, d);
      `CHK(d[4:0], nv_th)
      complete_run();
   end
endmodule // tb
